// ==== include/oc_pkg.sv ====
package oc_pkg;

  // Compare mode codes.
  typedef enum logic [2:0] {
    MODE_OFF      = 3'h0,
    MODE_SET_HIGH = 3'h1,
    MODE_SET_LOW  = 3'h2,
    MODE_TOGGLE   = 3'h3,
    MODE_SINGLE   = 3'h4,
    MODE_CONT     = 3'h5,
    MODE_PWM      = 3'h6,
    MODE_PWM_FLT  = 3'h7
  } mode_e;

  // Control word layout.
  localparam int CTRL_W = 4;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 2;
  localparam int TSEL_BIT = 3;
  localparam int CNT_W = 16;

  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // One timer's programming and run state.
  typedef struct packed {
    logic run;
    logic [15:0] period;
  } timer_cfg_s;

endpackage

// ==== verilog/oc_timebase.sv ====
`timescale 1ns/1ns
// One 16-bit up-counter with period-match reset.
module oc_timebase (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire oc_pkg::timer_cfg_s cfg_in,
  output logic [15:0] count_out,
  output logic period_hit_out
);

  wire logic at_period;
  wire logic step;

  assign at_period = (count_out == cfg_in.period);
  assign step = cfg_in.run & tick_in;
  // The wrap strobe is combinational so that a duty reload lands on the wrap edge itself.
  assign period_hit_out = step & at_period;

  // Period match wraps to zero and keeps counting.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count_out <= oc_pkg::COUNT_ZERO;
    end else begin
      if (step) begin
        count_out <= at_period ? oc_pkg::COUNT_ZERO : count_out + oc_pkg::COUNT_ONE;
      end
    end
  end

endmodule

// ==== verilog/oc_fault_sync.sv ====
`timescale 1ns/1ns
// Latches a fault request while the fault mode is active; only a mode change clears it.
module oc_fault_sync (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic fault_n_in,
  input wire logic armed_in,
  output logic fault_out
);

  // Hardware-only clear: leaving the fault mode drops the flag.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      fault_out <= 1'b0;
    end else if (!armed_in) begin
      fault_out <= 1'b0;
    end else if (!fault_n_in) begin
      fault_out <= 1'b1;
    end
  end

endmodule

// ==== verilog/output_compare_pulse_pwm.sv ====
`timescale 1ns/1ns
module output_compare_pulse_pwm (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic tick_in,
  input wire oc_pkg::timer_cfg_s timer_a_in,
  input wire oc_pkg::timer_cfg_s timer_b_in,
  input wire logic [oc_pkg::CTRL_W-1:0] ctrl_in,
  input wire logic ctrl_wr_in,
  input wire logic [15:0] primary_wdata_in,
  input wire logic primary_wr_in,
  input wire logic [15:0] secondary_wdata_in,
  input wire logic secondary_wr_in,
  input wire logic irq_flag_clr_in,
  input wire logic compare_irq_enable_in,
  input wire logic fault_input_n_in,
  output logic compare_out_pin_out,
  output logic compare_irq_flag_out,
  output logic irq_out,
  output logic fault_status_bit_out,
  output logic [15:0] primary_compare_reg_out,
  output logic [15:0] secondary_compare_reg_out,
  output logic [15:0] timebase_count_out
);

  // Pulse sequencer states, Gray coded along idle -> wait high -> wait low -> done.
  typedef enum logic [1:0] {
    ST_WAIT_RISE = 2'h0,
    ST_WAIT_FALL = 2'h1,
    ST_DONE = 2'h3,
    ST_IDLE = 2'h2
  } pulse_state_e;

  pulse_state_e state;
  pulse_state_e next_state;
  oc_pkg::mode_e mode;
  logic timebase_select;
  logic [15:0] primary_compare_reg;
  logic [15:0] secondary_compare_reg;
  logic pin;
  logic irq_flag;
  logic step_d;
  logic next_pin;

  wire logic [15:0] count_a;
  wire logic [15:0] count_b;
  wire logic hit_a;
  wire logic hit_b;
  wire logic fault;

  // Both time bases run here so either can be selected without a restart.
  oc_timebase u_tb_a (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_in),
    .cfg_in(timer_a_in),
    .count_out(count_a),
    .period_hit_out(hit_a)
  );

  oc_timebase u_tb_b (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .tick_in(tick_in),
    .cfg_in(timer_b_in),
    .count_out(count_b),
    .period_hit_out(hit_b)
  );

  // Timer selection and match decode.
  wire logic [15:0] timebase_count;
  wire oc_pkg::timer_cfg_s sel_cfg;
  wire logic period_hit;
  wire logic new_count;
  wire logic match_pri;
  wire logic match_sec;
  wire oc_pkg::mode_e wr_mode;
  wire logic is_pulse;
  wire logic is_pwm;
  wire logic pwm_high;
  assign timebase_count = timebase_select ? count_b : count_a;
  assign sel_cfg = timebase_select ? timer_b_in : timer_a_in;
  // Wrap strobe of the selected timer, high on the edge where its count returns to zero.
  assign period_hit = timebase_select ? hit_b : hit_a;
  // The count moved on the previous step; compare it exactly once.
  assign new_count = step_d;
  assign match_pri = new_count & (timebase_count == primary_compare_reg);
  assign match_sec = new_count & (timebase_count == secondary_compare_reg);
  assign wr_mode = oc_pkg::mode_e'(ctrl_in[oc_pkg::MODE_MSB:oc_pkg::MODE_LSB]);
  assign is_pulse = (mode == oc_pkg::MODE_SINGLE) | (mode == oc_pkg::MODE_CONT);
  assign is_pwm = (mode == oc_pkg::MODE_PWM) | (mode == oc_pkg::MODE_PWM_FLT);
  // High while count is below duty; zero duty never high, duty above period always high.
  assign pwm_high = (timebase_count < primary_compare_reg) & ~fault;

  oc_fault_sync u_fault (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .fault_n_in(fault_input_n_in),
    .armed_in(mode == oc_pkg::MODE_PWM_FLT),
    .fault_out(fault)
  );

  // Pin and sequencer next values.
  always_comb begin
    next_state = state;
    next_pin = pin;
    unique case (mode)
      oc_pkg::MODE_SINGLE, oc_pkg::MODE_CONT: begin
        unique case (state)
          ST_IDLE: next_state = ST_WAIT_RISE;
          ST_WAIT_RISE: begin
            if (match_pri) begin
              next_pin = 1'b1;
              next_state = ST_WAIT_FALL;
            end
          end
          ST_WAIT_FALL: begin
            if (match_sec) begin
              next_pin = 1'b0;
              next_state = (mode == oc_pkg::MODE_CONT) ? ST_WAIT_RISE : ST_DONE;
            end
          end
          ST_DONE: next_pin = 1'b0;
        endcase
      end
      oc_pkg::MODE_SET_HIGH: if (match_pri) next_pin = 1'b1;
      oc_pkg::MODE_SET_LOW: if (match_pri) next_pin = 1'b0;
      oc_pkg::MODE_TOGGLE: if (match_pri) next_pin = ~pin;
      oc_pkg::MODE_PWM, oc_pkg::MODE_PWM_FLT: next_pin = pwm_high;
      oc_pkg::MODE_OFF: next_pin = 1'b0;
    endcase
  end

  // Control writes: mode entry initialises the pin and re-arms the sequencer.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mode <= oc_pkg::MODE_OFF;
      timebase_select <= 1'b0;
      state <= ST_IDLE;
      pin <= 1'b0;
      step_d <= 1'b0;
    end else begin
      step_d <= tick_in & sel_cfg.run;
      if (ctrl_wr_in) begin
        mode <= wr_mode;
        timebase_select <= ctrl_in[oc_pkg::TSEL_BIT];
        state <= ST_IDLE;
        pin <= (wr_mode == oc_pkg::MODE_SET_LOW);
      end else begin
        state <= next_state;
        pin <= next_pin;
      end
    end
  end

  // Compare registers; primary is locked in PWM and reloaded from secondary at period end.
  // The reload shares the wrap edge, so a new period never starts on a stale duty.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      primary_compare_reg <= oc_pkg::REG_RESET;
      secondary_compare_reg <= oc_pkg::REG_RESET;
    end else begin
      if (secondary_wr_in) secondary_compare_reg <= secondary_wdata_in;
      if (is_pwm) begin
        if (period_hit) primary_compare_reg <= secondary_compare_reg;
      end else if (primary_wr_in) begin
        primary_compare_reg <= primary_wdata_in;
      end
    end
  end

  // Interrupt flag: a set in the same cycle as a clear wins.
  wire logic irq_set;
  assign irq_set = (is_pulse & (state == ST_WAIT_FALL) & match_sec) | (fault & ~fault_status_bit_out);
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      irq_flag <= 1'b0;
    end else if (irq_set) begin
      irq_flag <= 1'b1;
    end else if (irq_flag_clr_in) begin
      irq_flag <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      compare_out_pin_out <= 1'b0;
      compare_irq_flag_out <= 1'b0;
      irq_out <= 1'b0;
      fault_status_bit_out <= 1'b0;
      primary_compare_reg_out <= oc_pkg::REG_RESET;
      secondary_compare_reg_out <= oc_pkg::REG_RESET;
      timebase_count_out <= oc_pkg::COUNT_ZERO;
    end else begin
      compare_out_pin_out <= pin;
      compare_irq_flag_out <= irq_flag;
      irq_out <= irq_flag & compare_irq_enable_in;
      fault_status_bit_out <= fault;
      primary_compare_reg_out <= primary_compare_reg;
      secondary_compare_reg_out <= secondary_compare_reg;
      timebase_count_out <= timebase_count;
    end
  end

  // Pulse sequencer and off-mode checks.
  pin_low_entry_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ctrl_wr_in && (wr_mode == oc_pkg::MODE_SINGLE || wr_mode == oc_pkg::MODE_CONT) |=> !pin)
    else $error("pin not low after pulse mode write");
  rise_on_pri_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_wr_in && is_pulse && state == ST_WAIT_RISE && match_pri |=> pin)
    else $error("pin not high on primary match");
  fall_on_sec_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_wr_in && is_pulse && state == ST_WAIT_FALL && match_sec |=> !pin)
    else $error("pin not low on secondary match");
  single_stays_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    state == ST_DONE && mode == oc_pkg::MODE_SINGLE && !ctrl_wr_in |=> !pin)
    else $error("extra pulse in single mode");
  rearm_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ctrl_wr_in |=> state == ST_IDLE)
    else $error("sequencer not re-armed by mode write");
  cont_repeat_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_wr_in && mode == oc_pkg::MODE_CONT && state == ST_WAIT_FALL && match_sec
    |=> state == ST_WAIT_RISE)
    else $error("continuous mode did not re-arm");
  off_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_wr_in && mode == oc_pkg::MODE_OFF |=> !pin)
    else $error("pin driven while channel off");

  // Time base, selection and interrupt checks.
  tsel_take_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    ctrl_wr_in |=> timebase_select == $past(ctrl_in[oc_pkg::TSEL_BIT]))
    else $error("timer select not taken");
  wrap_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !ctrl_wr_in && period_hit |=> timebase_count == oc_pkg::COUNT_ZERO)
    else $error("count did not wrap to zero");
  irq_on_sec_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pulse && state == ST_WAIT_FALL && match_sec |=> irq_flag)
    else $error("irq flag missing");
  irq_gate_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    !compare_irq_enable_in |=> !irq_out)
    else $error("irq out while disabled");
  irq_pass_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    compare_irq_enable_in && irq_flag |=> irq_out)
    else $error("irq out missing while enabled");

  // PWM and fault checks; the duty register may only move on a wrap.
  duty_reload_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pwm && !period_hit |=> $stable(primary_compare_reg))
    else $error("duty changed off period match");
  duty_copy_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pwm && period_hit |=> primary_compare_reg == $past(secondary_compare_reg))
    else $error("duty not reloaded");
  sec_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    secondary_wr_in |=> secondary_compare_reg == $past(secondary_wdata_in))
    else $error("secondary write lost");
  zero_duty_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pwm && !ctrl_wr_in && primary_compare_reg == oc_pkg::COUNT_ZERO |=> !pin)
    else $error("zero duty not low");
  pwm_duty_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pwm && !ctrl_wr_in |=> pin == $past(pwm_high))
    else $error("pwm pin does not follow duty");
  fault_low_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fault && is_pwm && !ctrl_wr_in |=> !pin)
    else $error("pin driven during fault");

  // Scenario coverage.
  single_pulse_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mode == oc_pkg::MODE_SINGLE && state == ST_DONE);
  cont_irq_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mode == oc_pkg::MODE_CONT && irq_set);
  pwm_reload_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    is_pwm && period_hit);
  toggle_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    mode == oc_pkg::MODE_TOGGLE && match_pri);
  fault_c: cover property (@(posedge clk_sys_in) disable iff (!rst_n_in) fault);

endmodule

// ==== test/oc_load_model.sv ====
`timescale 1ns/1ns
// Load on the compare pin: counts rising edges and measures spans in clocks.
module oc_load_model (
  input wire logic clk_sys_in,
  input wire logic pin_in,
  input wire logic clear_in,
  output int rises_out,
  output int period_out,
  output int width_out
);
  logic last = 1'b0;
  int since_rise;

  // The pin is a registered output, so one sample a clock sees every level.
  always @(posedge clk_sys_in) begin
    last <= pin_in;
    since_rise <= since_rise + 1;
    if (clear_in) begin
      rises_out <= 0;
    end else if (pin_in && !last) begin
      rises_out <= rises_out + 1;
      period_out <= since_rise;
      since_rise <= 1;
    end else if (!pin_in && last) begin
      width_out <= since_rise;
    end
  end
endmodule

// ==== test/output_compare_pulse_pwm_test.sv ====
`timescale 1ns/1ns
// Drives the channel at the falling edge and judges the pin through a load model.
module output_compare_pulse_pwm_test;
  logic clk_sys_in = 1'b0;
  logic rst_n_in, tick_in, ctrl_wr_in, primary_wr_in, secondary_wr_in, irq_flag_clr_in;
  logic compare_irq_enable_in, fault_input_n_in;
  logic compare_out_pin_out, compare_irq_flag_out, irq_out, fault_status_bit_out;
  logic [oc_pkg::CTRL_W-1:0] ctrl_in;
  logic [15:0] primary_wdata_in, secondary_wdata_in, primary_compare_reg_out;
  logic [15:0] secondary_compare_reg_out, timebase_count_out;
  oc_pkg::timer_cfg_s timer_a_in, timer_b_in;
  logic [31:0] seed = 32'h68AD;
  int rises, period, width, errors, checks_done, per, p, s;

  // Half of the 20 ns period.
  always #10 clk_sys_in = ~clk_sys_in;

  output_compare_pulse_pwm uut (.clk_sys_in, .rst_n_in, .tick_in, .timer_a_in, .timer_b_in,
    .ctrl_in, .ctrl_wr_in, .primary_wdata_in, .primary_wr_in, .secondary_wdata_in,
    .secondary_wr_in, .irq_flag_clr_in, .compare_irq_enable_in, .fault_input_n_in,
    .compare_out_pin_out, .compare_irq_flag_out, .irq_out, .fault_status_bit_out,
    .primary_compare_reg_out, .secondary_compare_reg_out, .timebase_count_out);
  oc_load_model load (.clk_sys_in, .pin_in(compare_out_pin_out), .clear_in(irq_flag_clr_in),
    .rises_out(rises), .period_out(period), .width_out(width));

  // Case equality, so an unknown output never passes.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One strobe for one clock; which picks control, primary, secondary or flag clear.
  task automatic wr(input int which, input logic [15:0] v);
    @(negedge clk_sys_in);
    ctrl_in = v[3:0];
    primary_wdata_in = v;
    secondary_wdata_in = v;
    ctrl_wr_in = (which == 0);
    primary_wr_in = (which == 1);
    secondary_wr_in = (which == 2);
    irq_flag_clr_in = (which == 3);
    @(negedge clk_sys_in);
    {ctrl_wr_in, primary_wr_in, secondary_wr_in, irq_flag_clr_in} = 4'h0;
  endtask

  task automatic wc(input oc_pkg::mode_e m, input logic sel);
    wr(0, {12'h000, sel, m});
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // A mid-run reset also stops both timers so counts start from zero.
  task automatic do_reset();
    @(negedge clk_sys_in);
    rst_n_in = 1'b0;
    timer_a_in.run = 1'b0;
    timer_b_in.run = 1'b0;
    idle(2);
    rst_n_in = 1'b1;
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Far beyond the roughly 1000 clocks the sequence needs.
  initial begin
    #200000;
    errors++;
    final_report();
  end

  initial begin
    tick_in = 1'b1;
    {ctrl_wr_in, primary_wr_in, secondary_wr_in, irq_flag_clr_in} = 4'h0;
    ctrl_in = 4'h0;
    primary_wdata_in = 16'h0000;
    secondary_wdata_in = 16'h0000;
    compare_irq_enable_in = 1'b1;
    fault_input_n_in = 1'b1;
    timer_a_in = '{1'b0, 16'h0014};
    timer_b_in = '{1'b0, 16'h0014};
    rst_n_in = 1'b0;
    do_reset();
    // Single pulse from 4 to 9 in a 21-count period, then a re-arm without disable.
    wr(1, 16'h0004);
    wr(2, 16'h0009);
    wc(oc_pkg::MODE_SINGLE, 1'b0);
    timer_a_in.run = 1'b1;
    idle(70);
    check("rises", 16'(rises), 16'h0001);
    check("width", 16'(width), 16'h0005);
    check("flag", compare_irq_flag_out, 16'h0001);
    check("irq", irq_out, 16'h0001);
    wr(3, 16'h0000);
    wc(oc_pkg::MODE_SINGLE, 1'b0);
    idle(70);
    check("rearm", 16'(rises), 16'h0001);
    // Set high, then a pulse code pulling the high pin low at once, then set low, toggle and off.
    wc(oc_pkg::MODE_SET_HIGH, 1'b0);
    idle(30);
    check("set_high", compare_out_pin_out, 16'h0001);
    timer_a_in.run = 1'b0;
    wc(oc_pkg::MODE_SINGLE, 1'b0);
    idle(3);
    check("arm_low", compare_out_pin_out, 16'h0000);
    wc(oc_pkg::MODE_SET_LOW, 1'b0);
    idle(3);
    check("init_high", compare_out_pin_out, 16'h0001);
    timer_a_in.run = 1'b1;
    idle(30);
    check("set_low", compare_out_pin_out, 16'h0000);
    wc(oc_pkg::MODE_TOGGLE, 1'b0);
    idle(120);
    check("toggle", 16'(period), 16'h002A);
    wc(oc_pkg::MODE_OFF, 1'b0);
    wr(3, 16'h0000);
    idle(50);
    check("off", 16'(rises), 16'h0000);
    // Random trains on alternating timers; the other timer runs a longer period.
    for (int i = 0; i < 4; i++) begin
      do_reset();
      per = 8 + xs() % 24;
      p = 1 + xs() % (per - 1);
      s = p + 1 + xs() % (per - p);
      timer_a_in.period = 16'(i[0] ? per + 3 : per);
      timer_b_in.period = 16'(i[0] ? per : per + 3);
      compare_irq_enable_in = i[1];
      wr(1, 16'(p));
      wr(2, 16'(s));
      wc(oc_pkg::MODE_CONT, i[0]);
      timer_a_in.run = 1'b1;
      timer_b_in.run = 1'b1;
      idle(4 * per + 20);
      check("period", 16'(period), 16'(per + 1));
      check("cwidth", 16'(width), 16'(s - p));
      check("cflag", compare_irq_flag_out, 16'h0001);
      check("cirq", irq_out, 16'(i[1]));
      check("count_range", 16'(timebase_count_out <= 16'(per)), 16'h0001);
    end
    // PWM on a ten-count period: first duty from primary, later ones from secondary.
    do_reset();
    compare_irq_enable_in = 1'b1;
    timer_a_in.period = 16'h0009;
    wr(1, 16'h0003);
    wr(2, 16'h0006);
    check("count_zero", timebase_count_out, 16'h0000);
    wc(oc_pkg::MODE_PWM, 1'b0);
    timer_a_in.run = 1'b1;
    idle(12);
    check("duty_first", 16'(width), 16'h0003);
    idle(30);
    check("duty_next", 16'(width), 16'h0006);
    check("pwm_period", 16'(period), 16'h000A);
    wr(1, 16'h0001);
    idle(2);
    check("read_only", primary_compare_reg_out, 16'h0006);
    wr(2, 16'h0009);
    idle(30);
    check("duty_eq", 16'(width), 16'h0009);
    check("secondary", secondary_compare_reg_out, 16'h0009);
    wr(2, 16'h0000);
    idle(15);
    wr(3, 16'h0000);
    idle(25);
    check("duty_zero", 16'(rises), 16'h0000);
    wr(2, 16'h000C);
    idle(25);
    check("duty_full", compare_out_pin_out, 16'h0001);
    // A fault counts only in mode 111 and latches until that mode is left.
    fault_input_n_in = 1'b0;
    idle(3);
    check("no_fault", fault_status_bit_out, 16'h0000);
    wc(oc_pkg::MODE_PWM_FLT, 1'b0);
    idle(3);
    fault_input_n_in = 1'b1;
    idle(3);
    check("fault", fault_status_bit_out, 16'h0001);
    check("fault_pin", compare_out_pin_out, 16'h0000);
    check("fault_flag", compare_irq_flag_out, 16'h0001);
    wc(oc_pkg::MODE_PWM, 1'b0);
    idle(3);
    check("fault_clr", fault_status_bit_out, 16'h0000);
    final_report();
  end
endmodule
